// file: common/wdt_defines.svh
// constants of the windowed watchdog: field positions, reset values, timing counts
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ==========================================================
// configuration byte layout
`define WDT_CFG_CLOSED_HI 7
`define WDT_CFG_CLOSED_LO 4
`define WDT_CFG_OPEN_HI 3
`define WDT_CFG_OPEN_LO 0

// ==========================================================
// period code encoding
`define WDT_CODE_MAX 4'hb
`define WDT_BASE_CYCLES 16'h0008
`define WDT_SERVICE_KEY 8'ha5

// ==========================================================
// reset values, held until the user-row settings are loaded
`define WDT_RST_BIT 1'b0
`define WDT_RST_CODE 4'h0
`define WDT_RST_COUNT 16'h0000

// ==========================================================
// timing: one watchdog clock period, and the bus cycles it spans
`define WDT_TICK_PERIOD_NS 1000000
`define WDT_SYS_PERIOD_NS 10
`define WDT_TICK_CYCLES (`WDT_TICK_PERIOD_NS / `WDT_SYS_PERIOD_NS)

`endif

// file: common/wdt_pkg.sv
// types shared by the windowed watchdog
package wdt_pkg;

	// period, window or warning code
	typedef logic [3:0] wdt_code_t;

	// watchdog clock count within one time-out period
	typedef logic [15:0] wdt_count_t;

	// phase of the current time-out period
	typedef enum logic [1:0] {
		WDT_STOPPED,
		WDT_CLOSED,
		WDT_OPEN
	} wdt_phase_t;

endpackage : wdt_pkg

// file: rtl/wdt_core.sv
// windowed watchdog timer core with service key, early alert and persist lock
// Notes on behaviour
// (R01) writing enable one starts the watchdog, writing zero stops it
// (R02) a disable request is ignored while persist_lock is set
// (R03) normal mode: period elapsing without service raises system reset
// (R04) service byte 0xa5 restarts the count and a fresh period
// (R05) any other service byte raises system reset at once
// (R06) twelve period settings are selectable through open_period_code
// (R07) period codes 0..0xb give 8 doubling to 16384 watchdog clocks
// (R08) early alert interrupt starts disabled; set and clear strobes control it
// (R09) normal mode: early alert raised after warn_offset_code clocks from period start
// (R10) warn_offset_code uses the same doubling encoding as the period codes
// (R11) an offset not shorter than the period never raises early alert
// (R12) window mode: service inside the closed window raises system reset
// (R13) window mode: closed then open window, total period is their sum
// (R14) window mode: early alert raised when the open window begins
// (R15) persist_lock keeps the watchdog running; only power-on reset clears it
// (R16) persist_lock makes period and warning settings read-only
// (R17) window_mode_sel stays writable while persist_lock is set
// (R18) interrupt enable set and clear stay usable while persist_lock is set
// (R19) software must not set persist_lock while the watchdog clock is off
// (R20) alert flag set by condition; irq while flag and enable both set
// (R21) all interrupt sources share one irq output; flags tell them apart
// (R22) control or service write sets sync_pending until it reaches the watchdog clock
// (R23) a synced write while sync_pending is one stalls, then completes
// (R24) after power-on reset the settings load from user-row inputs
// (R25) while enabled, mode, lock, period and warning writes are discarded
// (R26) debug halt pauses the watchdog count
// (R27) writing one to the alert flag clears it; zero has no effect
`timescale 1ns/10ps
`include "wdt_defines.svh"

module wdt_core #(
	parameter int TICK_CYCLES = `WDT_TICK_CYCLES
) (
	// clock and power-on reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// user-row settings, captured after reset release
	input wire logic row_enable,
	input wire logic row_persist_lock,
	input wire logic row_window_mode_sel,
	input wire logic [3:0] row_closed_period_code,
	input wire logic [3:0] row_open_period_code,
	input wire logic [3:0] row_warn_offset_code,
	// control register write
	input wire logic ctrl_wr,
	input wire logic ctrl_enable,
	input wire logic ctrl_window_mode_sel,
	input wire logic ctrl_persist_lock,
	// period configuration write
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_wdata,
	// warning control write
	input wire logic warn_wr,
	input wire logic [3:0] warn_wdata,
	// interrupt enable and flag strobes
	input wire logic irq_set_wr,
	input wire logic irq_clr_wr,
	input wire logic flag_clr_wr,
	// service write
	input wire logic clear_wr,
	input wire logic [7:0] clear_wdata,
	// debug halt from the processor
	input wire logic debug_halt,
	// handshake
	output logic bus_stall,
	output logic sync_pending,
	// register readback
	output logic enable,
	output logic persist_lock,
	output logic window_mode_sel,
	output logic [3:0] closed_period_code,
	output logic [3:0] open_period_code,
	output logic [3:0] warn_offset_code,
	output logic irq_enable,
	output logic early_alert,
	output logic running,
	// results
	output logic irq,
	output logic sys_reset_req
);

	// ==========================================================
	// code to watchdog clock count, reserved codes clamp to the longest
	function automatic wdt_pkg::wdt_count_t code_cycles(input wdt_pkg::wdt_code_t code);
		wdt_pkg::wdt_code_t c;
		c = (code > `WDT_CODE_MAX) ? `WDT_CODE_MAX : code; // R07 R10
		return wdt_pkg::wdt_count_t'(`WDT_BASE_CYCLES << c); // R06
	endfunction : code_cycles

	// ==========================================================
	// tick divider: one-cycle enable per watchdog clock
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	logic [TICK_W-1:0] div_r;
	logic [TICK_W-1:0] div_nxt;
	logic tick;

	always_comb begin
		tick = (div_r == TICK_LAST);
		div_nxt = tick ? '0 : div_r + TICK_W'(1);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= '0;
		end else begin
			div_r <= div_nxt;
		end
	end

	// ==========================================================
	// register state, bus side
	logic loaded_r, loaded_nxt;
	logic en_r, en_nxt;
	logic lock_r, lock_nxt;
	logic win_r, win_nxt;
	wdt_pkg::wdt_code_t closed_r, closed_nxt;
	wdt_pkg::wdt_code_t open_r, open_nxt;
	wdt_pkg::wdt_code_t warn_r, warn_nxt;
	logic irq_en_r, irq_en_nxt;
	logic ctrl_pend_r, ctrl_pend_nxt;
	logic clr_pend_r, clr_pend_nxt;
	logic [7:0] clr_data_r, clr_data_nxt;

	// watchdog side
	logic run_r, run_nxt;
	wdt_pkg::wdt_count_t cnt_r, cnt_nxt;
	logic flag_r, flag_nxt;
	logic rst_req_r, rst_req_nxt;
	logic irq_r, irq_nxt;

	logic ctrl_take;
	logic clear_take;
	logic protect;
	wdt_pkg::wdt_count_t per_len;
	wdt_pkg::wdt_count_t closed_len;
	wdt_pkg::wdt_count_t warn_len;
	wdt_pkg::wdt_count_t end_len;
	wdt_pkg::wdt_count_t cnt_inc;
	logic alert_hit;
	logic bad_service;

	always_comb begin
		bus_stall = (ctrl_wr | clear_wr) & (ctrl_pend_r | clr_pend_r); // R23
		ctrl_take = ctrl_wr & ~bus_stall;
		clear_take = clear_wr & ~bus_stall;
		// stays set until the running state has settled, so protection covers disabling
		protect = en_r | run_r | lock_r; // R25
	end

	// ==========================================================
	// bus-side registers and write protection
	always_comb begin
		loaded_nxt = 1'b1;
		en_nxt = en_r;
		lock_nxt = lock_r;
		win_nxt = win_r;
		closed_nxt = closed_r;
		open_nxt = open_r;
		warn_nxt = warn_r;
		irq_en_nxt = irq_en_r;
		ctrl_pend_nxt = ctrl_pend_r;
		clr_pend_nxt = clr_pend_r;
		clr_data_nxt = clr_data_r;
		if (!loaded_r) begin
			en_nxt = row_enable; // R24
			lock_nxt = row_persist_lock;
			win_nxt = row_window_mode_sel;
			closed_nxt = row_closed_period_code;
			open_nxt = row_open_period_code;
			warn_nxt = row_warn_offset_code;
		end else begin
			// handed over on the watchdog clock
			if (tick) begin
				ctrl_pend_nxt = 1'b0; // R22
				clr_pend_nxt = 1'b0;
			end
			if (ctrl_take) begin
				ctrl_pend_nxt = 1'b1; // R22
				if (!lock_r) begin
					en_nxt = ctrl_enable; // R01 R02
				end
				if (!protect) begin
					lock_nxt = ctrl_persist_lock; // R25
				end else if (ctrl_persist_lock) begin
					// setting is allowed only while stopped; zero never clears it
					lock_nxt = lock_r; // R15
				end
				if (!protect || lock_r) begin
					win_nxt = ctrl_window_mode_sel; // R17 R25
				end
			end
			if (cfg_wr && !protect) begin
				closed_nxt = cfg_wdata[`WDT_CFG_CLOSED_HI:`WDT_CFG_CLOSED_LO]; // R16 R25
				open_nxt = cfg_wdata[`WDT_CFG_OPEN_HI:`WDT_CFG_OPEN_LO];
			end
			if (warn_wr && !protect) begin
				warn_nxt = warn_wdata; // R16 R25
			end
			if (clear_take) begin
				clr_pend_nxt = 1'b1; // R22
				clr_data_nxt = clear_wdata;
			end
			// set strobe wins over clear when both arrive together
			if (irq_clr_wr) begin
				irq_en_nxt = 1'b0; // R08 R18
			end
			if (irq_set_wr) begin
				irq_en_nxt = 1'b1; // R08 R18
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			loaded_r <= 1'b0;
			en_r <= `WDT_RST_BIT;
			lock_r <= `WDT_RST_BIT; // R15
			win_r <= `WDT_RST_BIT;
			closed_r <= `WDT_RST_CODE;
			open_r <= `WDT_RST_CODE;
			warn_r <= `WDT_RST_CODE;
			irq_en_r <= 1'b0; // R08
			ctrl_pend_r <= 1'b0;
			clr_pend_r <= 1'b0;
			clr_data_r <= 8'h00;
		end else begin
			loaded_r <= loaded_nxt;
			en_r <= en_nxt;
			lock_r <= lock_nxt;
			win_r <= win_nxt;
			closed_r <= closed_nxt;
			open_r <= open_nxt;
			warn_r <= warn_nxt;
			irq_en_r <= irq_en_nxt;
			ctrl_pend_r <= ctrl_pend_nxt;
			clr_pend_r <= clr_pend_nxt;
			clr_data_r <= clr_data_nxt;
		end
	end

	// ==========================================================
	// watchdog counting, service and early alert
	always_comb begin
		per_len = code_cycles(open_r);
		closed_len = code_cycles(closed_r);
		warn_len = code_cycles(warn_r);
		// the longest window sum, 16384 + 16384, still fits the 16-bit count
		end_len = win_r ? closed_len + per_len : per_len; // R13
		cnt_inc = cnt_r + 16'h0001;
		alert_hit = win_r ? (cnt_inc == closed_len) // R14
			: ((cnt_inc == warn_len) && (warn_len < per_len)); // R09 R11
		bad_service = (clr_data_r != `WDT_SERVICE_KEY) // R05
			|| (win_r && (cnt_r < closed_len)); // R12
		run_nxt = run_r;
		cnt_nxt = cnt_r;
		flag_nxt = flag_r;
		rst_req_nxt = 1'b0;
		if (tick && loaded_r) begin
			run_nxt = en_r | lock_r; // R01 R15
		end
		if (flag_clr_wr) begin
			flag_nxt = 1'b0; // R27
		end
		if (!run_r) begin
			cnt_nxt = `WDT_RST_COUNT;
		end else if (tick) begin
			if (clr_pend_r) begin
				if (bad_service) begin
					rst_req_nxt = 1'b1; // R05 R12
				end
				cnt_nxt = `WDT_RST_COUNT; // R04
			end else if (!debug_halt) begin // R26
				cnt_nxt = cnt_inc;
				if (alert_hit) begin
					flag_nxt = 1'b1; // R20
				end
				if (cnt_inc == end_len) begin
					rst_req_nxt = 1'b1; // R03
					cnt_nxt = `WDT_RST_COUNT;
				end
			end
		end
		irq_nxt = flag_nxt & irq_en_nxt; // R20 R21
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 1'b0;
			cnt_r <= `WDT_RST_COUNT;
			flag_r <= 1'b0;
			rst_req_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
			cnt_r <= cnt_nxt;
			flag_r <= flag_nxt;
			rst_req_r <= rst_req_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ==========================================================
	// outputs
	always_comb begin
		sync_pending = ctrl_pend_r | clr_pend_r; // R22
		enable = en_r;
		persist_lock = lock_r;
		window_mode_sel = win_r;
		closed_period_code = closed_r;
		open_period_code = open_r;
		warn_offset_code = warn_r;
		irq_enable = irq_en_r;
		early_alert = flag_r;
		running = run_r;
		irq = irq_r;
		sys_reset_req = rst_req_r;
	end

endmodule : wdt_core

// file: testbench/wdt_core_asserts.sv
// port checker for the windowed watchdog core
`timescale 1ns/10ps
module wdt_core_asserts #(
	parameter int TICK_CYCLES = 4
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// watched ports
	input wire logic ctrl_wr,
	input wire logic clear_wr,
	input wire logic irq_set_wr,
	input wire logic irq_clr_wr,
	input wire logic bus_stall,
	input wire logic sync_pending,
	input wire logic enable,
	input wire logic persist_lock,
	input wire logic irq_enable,
	input wire logic early_alert,
	input wire logic irq,
	input wire logic sys_reset_req
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// properties
	sequence s_sync_wr;
		(ctrl_wr || clear_wr) && !bus_stall;
	endsequence
	// crossing must finish within a few ticks of the short sim tick
	sequence s_sync_done;
		sync_pending ##[0:20] !sync_pending;
	endsequence
	property p_stall;
		bus_stall == ((ctrl_wr || clear_wr) && sync_pending);
	endproperty
	property p_sync;
		s_sync_wr |=> s_sync_done;
	endproperty
	property p_irq;
		irq == (early_alert && irq_enable);
	endproperty
	property p_ien_set;
		irq_set_wr |=> irq_enable;
	endproperty
	property p_ien_clr;
		irq_clr_wr && !irq_set_wr |=> !irq_enable;
	endproperty
	property p_lock;
		persist_lock |=> persist_lock;
	endproperty
	property p_lock_en;
		persist_lock && enable |=> enable;
	endproperty
	property p_pulse;
		sys_reset_req |=> !sys_reset_req;
	endproperty
	a_stall: assert property (p_stall) else $error("stall mismatch");
	a_sync: assert property (p_sync) else $error("sync not done");
	a_irq: assert property (p_irq) else $error("irq mismatch");
	a_ien_set: assert property (p_ien_set) else $error("enable set lost");
	a_ien_clr: assert property (p_ien_clr) else $error("enable clear lost");
	a_lock: assert property (p_lock) else $error("lock dropped");
	a_lock_en: assert property (p_lock_en) else $error("enable dropped");
	a_pulse: assert property (p_pulse) else $error("reset pulse long");
endmodule : wdt_core_asserts

// file: testbench/wdt_core_bench.sv
// self-checking bench for the windowed watchdog core
`timescale 1ns/10ps
module wdt_core_bench;
	localparam int T = 4;
	logic sys_clk, rst_n, row_enable, row_persist_lock, row_window_mode_sel, ctrl_wr;
	logic ctrl_enable, ctrl_window_mode_sel, ctrl_persist_lock, cfg_wr, warn_wr, irq_set_wr;
	logic irq_clr_wr, flag_clr_wr, clear_wr, debug_halt, bus_stall, sync_pending, enable;
	logic persist_lock, window_mode_sel, irq_enable, early_alert, running, irq, sys_reset_req;
	logic [3:0] row_closed_period_code, row_open_period_code, row_warn_offset_code, warn_wdata;
	logic [3:0] closed_period_code, open_period_code, warn_offset_code;
	logic [7:0] cfg_wdata, clear_wdata, b;
	int num_errors, n_compared, n, n_rst, seed;

	wdt_core #(.TICK_CYCLES(T)) u_wdt_core (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.row_enable(row_enable),
		.row_persist_lock(row_persist_lock),
		.row_window_mode_sel(row_window_mode_sel),
		.row_closed_period_code(row_closed_period_code),
		.row_open_period_code(row_open_period_code),
		.row_warn_offset_code(row_warn_offset_code),
		.ctrl_wr(ctrl_wr),
		.ctrl_enable(ctrl_enable),
		.ctrl_window_mode_sel(ctrl_window_mode_sel),
		.ctrl_persist_lock(ctrl_persist_lock),
		.cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata),
		.warn_wr(warn_wr),
		.warn_wdata(warn_wdata),
		.irq_set_wr(irq_set_wr),
		.irq_clr_wr(irq_clr_wr),
		.flag_clr_wr(flag_clr_wr),
		.clear_wr(clear_wr),
		.clear_wdata(clear_wdata),
		.debug_halt(debug_halt),
		.bus_stall(bus_stall),
		.sync_pending(sync_pending),
		.enable(enable),
		.persist_lock(persist_lock),
		.window_mode_sel(window_mode_sel),
		.closed_period_code(closed_period_code),
		.open_period_code(open_period_code),
		.warn_offset_code(warn_offset_code),
		.irq_enable(irq_enable),
		.early_alert(early_alert),
		.running(running),
		.irq(irq),
		.sys_reset_req(sys_reset_req)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// counted on the pulse itself so a clear at the next falling edge cannot race it
	always @(posedge sys_reset_req) begin
		n_rst++;
	end
	// ==========================================================
	// reference model and helpers
	function int tmo(input int code);
		return (8 << code) * T;
	endfunction : tmo
	function logic [3:0] rc;
		return 4'(($random(seed) & 32'h7fff) % 12);
	endfunction : rc
	task chk(input logic [31:0] g, e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task stop_test;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	// holds the strobe across every stalled edge, released after the edge that takes it
	task automatic pulse(ref logic s);
		logic st;
		s = 1'b1;
		do begin
			#1 st = bus_stall;
			@(negedge sys_clk);
		end while (st === 1'b1);
		s = 1'b0;
	endtask : pulse
	task idle;
		while (sync_pending !== 1'b0) @(negedge sys_clk);
	endtask : idle
	task ctl(input logic e, w, l);
		idle();
		{ctrl_enable, ctrl_window_mode_sel, ctrl_persist_lock} = {e, w, l};
		pulse(ctrl_wr);
		idle();
	endtask : ctl
	task svc(input logic [7:0] d);
		idle();
		clear_wdata = d;
		pulse(clear_wr);
	endtask : svc
	// counts falling edges until the watched output is seen high
	task automatic wait_hi(ref logic s, output int k);
		k = 0;
		do begin
			@(negedge sys_clk);
			k++;
		end while (s !== 1'b1 && k < 3000);
	endtask : wait_hi
	task cfg(input logic [7:0] c, input logic [3:0] w);
		cfg_wdata = c;
		warn_wdata = w;
		pulse(cfg_wr);
		pulse(warn_wr);
	endtask : cfg
	// ==========================================================
	// main sequence
	initial begin
		seed = 32'h7be9;
		{rst_n, ctrl_wr, ctrl_enable, ctrl_window_mode_sel, ctrl_persist_lock} = '0;
		{cfg_wr, warn_wr, irq_set_wr, irq_clr_wr, flag_clr_wr, clear_wr, debug_halt} = '0;
		{cfg_wdata, clear_wdata, warn_wdata, row_enable, row_persist_lock} = '0;
		row_window_mode_sel = 1'($random(seed));
		{row_closed_period_code, row_open_period_code, row_warn_offset_code} = {rc(), rc(), rc()};
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk({enable, persist_lock, window_mode_sel, closed_period_code, open_period_code,
			warn_offset_code}, {2'b00, row_window_mode_sel, row_closed_period_code,
			row_open_period_code, row_warn_offset_code});
		ctl(1'b0, 1'b0, 1'b0);
		cfg(8'h01, 4'h0);
		pulse(irq_set_wr);
		ctl(1'b1, 1'b0, 1'b0);
		wait_hi(sys_reset_req, n);
		pulse(flag_clr_wr);
		wait_hi(early_alert, n);
		chk(n + 1, tmo(0));
		chk(irq, 1'b1);
		wait_hi(sys_reset_req, n);
		chk(n + tmo(0), tmo(1));
		ctl(1'b0, 1'b0, 1'b0);
		cfg(8'h00, 4'h0);
		ctl(1'b1, 1'b0, 1'b0);
		wait_hi(sys_reset_req, n);
		pulse(flag_clr_wr);
		wait_hi(sys_reset_req, n);
		chk(n + 1, tmo(0));
		chk(early_alert, 1'b0);
		n_rst = 0;
		repeat (5) begin
			repeat (12) @(negedge sys_clk);
			svc(8'ha5);
		end
		// second service while the first is still crossing: held, then taken
		clear_wr = 1'b1;
		@(negedge sys_clk);
		chk(bus_stall, 1'b1);
		pulse(clear_wr);
		chk(sync_pending, 1'b1);
		chk(n_rst, 0);
		b = 8'($random(seed));
		if (b == 8'ha5) b = 8'h00;
		svc(b);
		wait_hi(sys_reset_req, n);
		chk(n <= 2 * T, 1'b1);
		debug_halt = 1'b1;
		n_rst = 0;
		repeat (200) @(negedge sys_clk);
		debug_halt = 1'b0;
		chk(n_rst, 0);
		ctl(1'b0, 1'b0, 1'b0);
		repeat (100) @(negedge sys_clk);
		chk({enable, running}, 2'b00);
		chk(n_rst, 0);
		pulse(irq_clr_wr);
		chk(irq_enable, 1'b0);
		ctl(1'b0, 1'b1, 1'b0);
		ctl(1'b1, 1'b1, 1'b0);
		wait_hi(sys_reset_req, n);
		pulse(flag_clr_wr);
		wait_hi(early_alert, n);
		chk(n + 1, tmo(0));
		wait_hi(sys_reset_req, n);
		chk(n + tmo(0), 2 * tmo(0));
		// well inside the open window the key is accepted
		n_rst = 0;
		repeat (40) @(negedge sys_clk);
		svc(8'ha5);
		idle();
		chk(n_rst, 0);
		svc(8'ha5);
		wait_hi(sys_reset_req, n);
		chk(n <= 2 * T, 1'b1);
		ctl(1'b0, 1'b1, 1'b0);
		ctl(1'b0, 1'b1, 1'b1);
		cfg(8'h33, 4'h5);
		ctl(1'b0, 1'b0, 1'b0);
		repeat (3 * T) @(negedge sys_clk);
		chk({running, persist_lock, window_mode_sel}, 3'b110);
		chk({open_period_code, warn_offset_code}, 8'h00);
		pulse(irq_set_wr);
		chk(irq_enable, 1'b1);
		stop_test();
	end
	initial begin
		#300000;
		num_errors++;
		stop_test();
	end
endmodule : wdt_core_bench

bind wdt_core wdt_core_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_wdt_core_asserts (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.ctrl_wr(ctrl_wr),
	.clear_wr(clear_wr),
	.irq_set_wr(irq_set_wr),
	.irq_clr_wr(irq_clr_wr),
	.bus_stall(bus_stall),
	.sync_pending(sync_pending),
	.enable(enable),
	.persist_lock(persist_lock),
	.irq_enable(irq_enable),
	.early_alert(early_alert),
	.irq(irq),
	.sys_reset_req(sys_reset_req)
);
